// ==== alu_flags_pkg.sv ====
package alu_flags_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the Avalon-MM word bus
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_OPERAND = 4'h4;
  localparam logic [3:0] OFS_COMMAND = 4'h8;
  localparam logic [3:0] OFS_RESULT = 4'hC;

  // Flag bit positions inside the flag register
  localparam int BIT_NEG = 4;
  localparam int BIT_WRAP = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_HALF = 1;
  localparam int BIT_TOP = 0;

  // Operand register fields
  localparam int OPR_WORK_LSB = 0;
  localparam int OPR_FILE_LSB = 8;
  localparam int OPR_SRC_FLAGS = 16;
  localparam int OPR_BITSEL_LSB = 17;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_FLAGS = 4;

  // Result register fields
  localparam int RES_DISCARD = 8;
  localparam int RES_DEST_FLAGS = 9;

  // Reset values
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] BITSEL_RESET = 3'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction codes, as written to the command register
  typedef enum logic [3:0] {
    OP_ADD_WORK_FILE = 4'h0,
    OP_ADD_LITERAL_WORK = 4'h1,
    OP_LITERAL_MINUS_WORK = 4'h2,
    OP_FILE_MINUS_WORK = 4'h3,
    OP_ROTATE_RIGHT = 4'h4,
    OP_ROTATE_LEFT = 4'h5,
    OP_CLEAR_FILE = 4'h6,
    OP_BIT_CLEAR = 4'h7,
    OP_BIT_SET = 4'h8,
    OP_NIBBLE_EXCHANGE = 4'h9,
    OP_FILE_TO_FILE_COPY = 4'hA,
    OP_WORK_TO_FILE_COPY = 4'hB,
    OP_AND_WORK_FILE = 4'hC
  } opcode_t;

  // Five implemented flags, bit 4 down to bit 0
  typedef struct packed {
    logic neg;
    logic wrap;
    logic zero;
    logic half;
    logic top;
  } flags_t;

  // Outcome of the adder
  typedef struct packed {
    logic [7:0] sum;
    logic half_carry;
    logic top_carry;
    logic wrap;
  } add_out_t;

  // Bus handshake state
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage : alu_flags_pkg

// ==== flag_adder.sv ====
`timescale 1ns/1ps
`default_nettype none

// Eight-bit adder with nibble carry, top carry and signed overflow
module flag_adder (
  input wire logic [7:0] addend_a,
  input wire logic [7:0] addend_b,
  input wire logic carry_in,
  output alu_flags_pkg::add_out_t outcome
);

  logic [4:0] low_sum;
  logic [4:0] high_sum;

  // Split at the nibble so the digit carry falls out for free
  always_comb begin
    low_sum = {1'b0, addend_a[3:0]} + {1'b0, addend_b[3:0]} + {4'h0, carry_in};
    high_sum = {1'b0, addend_a[7:4]} + {1'b0, addend_b[7:4]} + {4'h0, low_sum[4]};
    outcome.sum = {high_sum[3:0], low_sum[3:0]};
    outcome.half_carry = low_sum[4];
    outcome.top_carry = high_sum[4];
    // Same-sign inputs giving the other sign means the magnitude wrapped
    outcome.wrap = (addend_a[7] == addend_b[7]) && (high_sum[3] != addend_a[7]);
  end

endmodule : flag_adder

`default_nettype wire

// ==== alu_status_flags.sv ====
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Flag-affecting op with flag register destination: drop result, just update flags.
// - clear_file on flag register sets only the zero flag, others kept.
// - Bit clear/set, nibble exchange and both copies leave flags untouched unless the flag register is their destination.
// - Bits 7 to 5 of the flag register always read zero.
// - Negative flag, bit 4, follows result bit 7, except clear_file, which keeps it.
// - Overflow flag, bit 3, set when signed result wraps the sign.
// - Zero flag, bit 2, set exactly when the result is zero.
// - Adds and subtracts put the carry out of bit 3 in bit 1.
// - Adds and subtracts put the carry out of bit 7 in bit 0.
// - Subtract adds the two's complement; carries are active-low borrows.
// - Rotates load bit 0 with the bit shifted out of the source.
// - Flag register is usable as source or destination of any instruction.
module alu_status_flags (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output alu_flags_pkg::flags_t flags
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  alu_flags_pkg::bus_state_t bus_state;
  alu_flags_pkg::bus_state_t next_bus_state;
  logic next_waitrequest;
  logic [31:0] next_readdata;

  alu_flags_pkg::flags_t next_flags;
  logic [7:0] work_value;
  logic [7:0] next_work_value;
  logic [7:0] file_value;
  logic [7:0] next_file_value;
  logic source_is_flags;
  logic next_source_is_flags;
  logic [2:0] bit_select;
  logic [2:0] next_bit_select;
  logic [7:0] result_value;
  logic [7:0] next_result_value;
  logic result_discarded;
  logic next_result_discarded;
  logic last_dest_flags;
  logic next_last_dest_flags;

  // Instruction decode and datapath wires
  logic request;
  logic commit;
  logic write_flags_reg;
  logic write_operand_reg;
  logic write_command_reg;
  alu_flags_pkg::opcode_t opcode;
  logic dest_flags;
  logic [7:0] src_file;
  logic [7:0] adder_a;
  logic [7:0] adder_b;
  logic adder_cin;
  alu_flags_pkg::add_out_t add_out;
  logic [7:0] op_result;
  alu_flags_pkg::flags_t op_flags;
  logic op_affects_flags;

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  assign request = avs_read || avs_write;
  // Writes land only on the edge that completes the transfer
  assign commit = request && (bus_state == alu_flags_pkg::BUS_ANSWER);
  assign write_flags_reg = commit && avs_write && (avs_address == alu_flags_pkg::OFS_FLAGS)
    && avs_byteenable[0];
  assign write_operand_reg = commit && avs_write && (avs_address == alu_flags_pkg::OFS_OPERAND);
  assign write_command_reg = commit && avs_write && (avs_address == alu_flags_pkg::OFS_COMMAND)
    && avs_byteenable[0];

  // One wait cycle, then one answer cycle with waitrequest low
  always_comb begin
    next_bus_state = alu_flags_pkg::BUS_IDLE;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    case (bus_state)
      alu_flags_pkg::BUS_IDLE: begin
        if (request) begin
          next_bus_state = alu_flags_pkg::BUS_ANSWER;
          next_waitrequest = 1'b0;
          next_readdata = 32'h0000_0000;
          if (avs_read) begin
            case (avs_address)
              alu_flags_pkg::OFS_FLAGS: begin
                next_readdata = {27'h0000000, flags};
              end
              alu_flags_pkg::OFS_OPERAND: begin
                next_readdata = {12'h000, bit_select, source_is_flags, file_value, work_value};
              end
              alu_flags_pkg::OFS_RESULT: begin
                next_readdata = {22'h000000, last_dest_flags, result_discarded, result_value};
              end
              default: begin
                next_readdata = 32'h0000_0000; // Unmapped and command read as zero
              end
            endcase
          end
        end
      end
      alu_flags_pkg::BUS_ANSWER: begin
        // Back to idle so a held request cannot complete in two cycles in a row
        next_bus_state = alu_flags_pkg::BUS_IDLE;
        next_waitrequest = 1'b1;
      end
      default: begin
        next_bus_state = alu_flags_pkg::BUS_IDLE;
      end
    endcase
  end

  // Handshake registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_state <= alu_flags_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operand selection and adder

  assign opcode = alu_flags_pkg::opcode_t'(avs_writedata[alu_flags_pkg::CMD_OP_LSB +: 4]);
  assign dest_flags = avs_writedata[alu_flags_pkg::CMD_DEST_FLAGS];
  // The flag register can stand in as the file operand
  assign src_file = source_is_flags ? {3'h0, flags} : file_value;

  // Subtraction feeds the inverted subtrahend with a carry in of one
  always_comb begin
    adder_a = src_file;
    adder_b = work_value;
    adder_cin = 1'b0;
    case (opcode)
      alu_flags_pkg::OP_LITERAL_MINUS_WORK, alu_flags_pkg::OP_FILE_MINUS_WORK: begin
        adder_b = ~work_value;
        adder_cin = 1'b1;
      end
      default: begin
        adder_b = work_value;
      end
    endcase
  end

  flag_adder adder_inst (
    .addend_a(adder_a),
    .addend_b(adder_b),
    .carry_in(adder_cin),
    .outcome(add_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Result and flag update per instruction

  always_comb begin
    op_result = src_file;
    op_flags = flags;
    op_affects_flags = 1'b0;
    case (opcode)
      alu_flags_pkg::OP_ADD_WORK_FILE, alu_flags_pkg::OP_ADD_LITERAL_WORK,
      alu_flags_pkg::OP_LITERAL_MINUS_WORK, alu_flags_pkg::OP_FILE_MINUS_WORK: begin
        op_result = add_out.sum;
        op_affects_flags = 1'b1;
        op_flags.neg = add_out.sum[7];
        op_flags.wrap = add_out.wrap;
        op_flags.zero = (add_out.sum == 8'h00);
        op_flags.half = add_out.half_carry;
        op_flags.top = add_out.top_carry;
      end
      alu_flags_pkg::OP_ROTATE_RIGHT: begin
        // Rotate goes through the carry flag
        op_result = {flags.top, src_file[7:1]};
        op_affects_flags = 1'b1;
        op_flags.top = src_file[0];
        op_flags.neg = flags.top;
        op_flags.zero = ({flags.top, src_file[7:1]} == 8'h00);
      end
      alu_flags_pkg::OP_ROTATE_LEFT: begin
        op_result = {src_file[6:0], flags.top};
        op_affects_flags = 1'b1;
        op_flags.top = src_file[7];
        op_flags.neg = src_file[6];
        op_flags.zero = ({src_file[6:0], flags.top} == 8'h00);
      end
      alu_flags_pkg::OP_CLEAR_FILE: begin
        op_result = 8'h00;
        op_affects_flags = 1'b1;
        op_flags.zero = 1'b1;
      end
      alu_flags_pkg::OP_AND_WORK_FILE: begin
        op_result = src_file & work_value;
        op_affects_flags = 1'b1;
        op_flags.neg = src_file[7] & work_value[7];
        op_flags.zero = ((src_file & work_value) == 8'h00);
      end
      // These five leave the flags alone unless the flag register is the destination
      alu_flags_pkg::OP_BIT_CLEAR: begin
        op_result = src_file & ~(8'h01 << bit_select);
      end
      alu_flags_pkg::OP_BIT_SET: begin
        op_result = src_file | (8'h01 << bit_select);
      end
      alu_flags_pkg::OP_NIBBLE_EXCHANGE: begin
        op_result = {src_file[3:0], src_file[7:4]};
      end
      alu_flags_pkg::OP_FILE_TO_FILE_COPY: begin
        op_result = src_file;
      end
      alu_flags_pkg::OP_WORK_TO_FILE_COPY: begin
        op_result = work_value;
      end
      default: begin
        op_result = src_file; // Unused codes behave as a flag-free copy
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Architectural registers

  always_comb begin
    next_flags = flags;
    next_work_value = work_value;
    next_file_value = file_value;
    next_source_is_flags = source_is_flags;
    next_bit_select = bit_select;
    next_result_value = result_value;
    next_result_discarded = result_discarded;
    next_last_dest_flags = last_dest_flags;
    if (write_flags_reg) begin
      next_flags = alu_flags_pkg::flags_t'(avs_writedata[4:0]);
    end
    if (write_operand_reg) begin
      if (avs_byteenable[0]) begin
        next_work_value = avs_writedata[alu_flags_pkg::OPR_WORK_LSB +: 8];
      end
      if (avs_byteenable[1]) begin
        next_file_value = avs_writedata[alu_flags_pkg::OPR_FILE_LSB +: 8];
      end
      if (avs_byteenable[2]) begin
        next_source_is_flags = avs_writedata[alu_flags_pkg::OPR_SRC_FLAGS];
        next_bit_select = avs_writedata[alu_flags_pkg::OPR_BITSEL_LSB +: 3];
      end
    end
    if (write_command_reg) begin
      next_last_dest_flags = dest_flags;
      next_result_value = op_result;
      next_result_discarded = dest_flags && op_affects_flags;
      if (op_affects_flags) begin
        // With the flags as destination the flag update wins over the result
        next_flags = op_flags;
      end else if (dest_flags) begin
        next_flags = alu_flags_pkg::flags_t'(op_result[4:0]);
      end
      if (dest_flags && op_affects_flags) begin
        next_result_value = {3'h0, op_flags};
      end else if (dest_flags) begin
        next_result_value = {3'h0, op_result[4:0]};
      end
    end
  end

  // Flags power up undefined in silicon; cleared here for a known start
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= alu_flags_pkg::FLAGS_RESET;
      work_value <= alu_flags_pkg::BYTE_RESET;
      file_value <= alu_flags_pkg::BYTE_RESET;
      source_is_flags <= 1'b0;
      bit_select <= alu_flags_pkg::BITSEL_RESET;
      result_value <= alu_flags_pkg::BYTE_RESET;
      result_discarded <= 1'b0;
      last_dest_flags <= 1'b0;
    end else begin
      flags <= next_flags;
      work_value <= next_work_value;
      file_value <= next_file_value;
      source_is_flags <= next_source_is_flags;
      bit_select <= next_bit_select;
      result_value <= next_result_value;
      result_discarded <= next_result_discarded;
      last_dest_flags <= next_last_dest_flags;
    end
  end

endmodule : alu_status_flags

`default_nettype wire

// ==== alu_flags_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

// Watches the bus handshake and the flag outputs of the status block
module alu_flags_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire alu_flags_pkg::flags_t flags
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Completed transfers; only these may move the flags
  logic wr_done;
  logic rd_done;
  logic cmd_lo;
  assign wr_done = avs_write && !avs_waitrequest;
  assign rd_done = avs_read && !avs_waitrequest;
  assign cmd_lo = wr_done && avs_address == alu_flags_pkg::OFS_COMMAND && avs_byteenable[0];

  //////////////////////////////////////////////////////////////////////////////
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_single;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_single: assert property (p_single) else $error("answer longer than one cycle");
  property p_cause;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_rd_flags;
    rd_done && avs_address == alu_flags_pkg::OFS_FLAGS |-> avs_readdata == {27'h0, flags};
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read wrong");
  property p_rd_void;
    rd_done && (avs_address == alu_flags_pkg::OFS_COMMAND || avs_address[1:0] != 2'h0)
      |-> avs_readdata == 32'h0;
  endproperty
  a_rd_void: assert property (p_rd_void) else $error("void read not zero");
  property p_hold;
    !(wr_done && (avs_address == alu_flags_pkg::OFS_FLAGS || cmd_lo)) |=> $stable(flags);
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved without cause");
  property p_wr;
    wr_done && avs_address == alu_flags_pkg::OFS_FLAGS && avs_byteenable[0]
      |=> flags == $past(avs_writedata[4:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("flag write lost");
  property p_quiet;
    cmd_lo && !avs_writedata[4] && avs_writedata[3:0] inside {[4'h7:4'hB]} |=> $stable(flags);
  endproperty
  a_quiet: assert property (p_quiet) else $error("flag-free op moved flags");
  // Clear on the flag register only raises zero
  property p_clear;
    cmd_lo && avs_writedata[4:0] == 5'h16 |=> flags.zero && flags[4:3] == $past(flags[4:3])
      && flags[1:0] == $past(flags[1:0]);
  endproperty
  a_clear: assert property (p_clear) else $error("clear of flags wrong");
  c_cmd: cover property (cmd_lo);
  c_clear: cover property (cmd_lo && avs_writedata[4:0] == 5'h16);
  c_rd: cover property (rd_done && avs_address == alu_flags_pkg::OFS_FLAGS);
endmodule : alu_flags_asserts

bind alu_status_flags alu_flags_asserts chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flags(flags));

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic sys_clk;
  logic sys_rst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  alu_flags_pkg::flags_t flags;
  int n_fail;
  int cmp_count;
  logic [31:0] q;

  alu_status_flags dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flags(flags));

  // Free-running 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_w

  task automatic chk_f(input string what, input logic [4:0] exp);
    cmp_count++;
    if (flags !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, flags);
    end
  endtask : chk_f

  // One Avalon transfer; bounded wait so a dead slave shows as a mismatch
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    chk_w("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_w("read data", exp, q);
  endtask : rdc

  task automatic wflags(input logic [31:0] d);
    bus(1'b1, alu_flags_pkg::OFS_FLAGS, d);
  endtask : wflags

  task automatic wopnd(input logic [31:0] d);
    bus(1'b1, alu_flags_pkg::OFS_OPERAND, d);
  endtask : wopnd

  task automatic wcmd(input logic [31:0] d);
    bus(1'b1, alu_flags_pkg::OFS_COMMAND, d);
  endtask : wcmd

  task automatic rres(input logic [31:0] exp);
    rdc(alu_flags_pkg::OFS_RESULT, exp);
  endtask : rres

  // Reference adder: sum then neg, wrap, zero, half, top
  function automatic logic [12:0] addm(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h0, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {s[7:0], s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h0, h[4], s[8]};
  endfunction : addm

  //////////////////////////////////////////////////////////////////////////////
  // All four add and subtract codes over sign, zero and borrow corners
  task automatic t_arith();
    logic [7:0] fv [4];
    logic [7:0] wv [4];
    logic [12:0] e;
    logic sub;
    fv = '{8'h7F, 8'hFF, 8'h05, 8'h80};
    wv = '{8'h01, 8'h01, 8'h05, 8'h01};
    for (int op = 0; op < 4; op++) begin
      for (int i = 0; i < 4; i++) begin
        sub = op >= 2;
        e = addm(fv[i], sub ? ~wv[i] : wv[i], sub);
        wopnd({16'h0, fv[i], wv[i]});
        wcmd({28'h0, 4'(op)});
        chk_f("arith flags", e[4:0]);
        rres({24'h0, e[12:5]});
      end
    end
  endtask : t_arith

  // Rotates through carry, carry picks the bit shifted out
  task automatic t_rot();
    wflags(32'h01);
    wopnd(32'h00008000);
    wcmd(32'h04);
    chk_f("rotate right", 5'h10);
    rres(32'h000000C0);
    wcmd(32'h05);
    chk_f("rotate left", 5'h05);
  endtask : t_rot

  task automatic t_dest();
    wopnd(32'h00007F01);
    wcmd(32'h10);
    chk_f("dest add", 5'h1A);
    rres(32'h0000031A);
    wflags(32'h1B);
    wcmd(32'h16);
    chk_f("clear flags", 5'h1F);
    wopnd(32'h00000FF0);
    wcmd(32'h0C);
    chk_f("and flags", 5'h0F);
    wflags(32'hFFFFFFFF);
    rdc(alu_flags_pkg::OFS_FLAGS, 32'h0000001F);
  endtask : t_dest

  // Flag-free ops, with and without the flag register as target
  task automatic t_quiet();
    logic [7:0] rv [5];
    rv = '{8'hA4, 8'hA5, 8'h5A, 8'hA5, 8'h35};
    wopnd(32'h0000A535);
    for (int i = 0; i < 5; i++) begin
      wflags(32'h0A);
      wcmd(32'h7 + i);
      chk_f("quiet flags", 5'h0A);
      rres({24'h0, rv[i]});
      wcmd(32'h17 + i);
      chk_f("stored flags", rv[i][4:0]);
    end
    wflags(32'h03);
    wopnd(32'h0009A535);
    wcmd(32'h18);
    chk_f("source flags", 5'h13);
  endtask : t_quiet

  // Lane 0 off and unmapped places must leave everything alone
  task automatic t_refuse();
    wflags(32'h0A);
    avs_byteenable <= 4'hE;
    wflags(32'h15);
    avs_byteenable <= 4'hF;
    chk_f("lane refused", 5'h0A);
    bus(1'b1, 4'h2, 32'h1F);
    chk_f("unmapped write", 5'h0A);
    rdc(4'h1, 32'h0);
    rdc(alu_flags_pkg::OFS_COMMAND, 32'h0);
    // Spare code copies the file operand, here the flags, and keeps the flags
    wcmd(32'h0D);
    chk_f("spare code flags", 5'h0A);
    rres(32'h0000000A);
    // Clear aimed elsewhere still raises zero from its zero result
    wcmd(32'h06);
    chk_f("clear elsewhere flags", 5'h0E);
    rres(32'h00000000);
  endtask : t_refuse

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 12 cycles, then the scenarios
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk_f("reset flags", 5'h00);
    t_arith();
    t_rot();
    t_dest();
    t_quiet();
    t_refuse();
    report_and_stop();
  end

  // Watchdog, far beyond the few hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
